/* rtl/usb_device_command_port.sv */
// Command interpreter of the device controller's processor port
`timescale 1ns/1ps
`default_nettype none
`include "udc_cmd_map.svh"

// What this block does
// - Select high: low byte is a command code.
// - Commands without data act at once.
// - Select low: data to chosen register or FIFO.
// - Wide registers move low word first.
// - High command byte ignored; word accesses only.
// - Odd packet: final high byte not sent.
// - Buffer starts with two-byte packet length.
// - Endpoint configuration codes 20-2F write, 30-3F read.
// - Address B6/B7, mode B8/B9, hardware BA/BB.
// - Interrupt enable C2/C3, two words.
// - DMA config F0/F1, counter F2/F3.
// - F6 clears the endpoint configuration and device registers.
// - Codes 01-0F load IN buffers.
// - Codes 10, 12-1F read OUT buffers.
// - Stall 40-4F, unstall 80-8F, no data.
// - Codes 50-5F read endpoint status.
// - Codes D0-DF read status copy.
// - Codes 61-6F validate IN buffers.
// - Codes 70, 72-7F clear OUT buffers.
// - F4 acknowledges setup on control endpoints.
// - A0/A1 read control error codes.
// - Status copy read changes no bits.
// - N-byte buffer takes (N+1)/2 words.
module usb_device_command_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Processor bus
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic cmd_data_select,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  // USB engine: status and buffers
  input wire logic [15:0][7:0] endpoint_status_reg,
  input wire logic [1:0][7:0] endpoint_error_reg,
  input wire logic [15:0] buf_rd_data,
  output logic buf_rd_req,
  output udc_cmd_pkg::buf_word_t buf_wr,
  output udc_cmd_pkg::ep_cmd_t ep_cmd,
  // Configuration seen by the engine
  output logic [15:0][7:0] endpoint_config_reg,
  output udc_cmd_pkg::dev_cfg_t dev_cfg
);

  // ==========================================================================
  // Command decoding
  function automatic udc_cmd_pkg::target_t cmd_target(input logic [7:0] code);
    case (code[7:4])
      `GRP_BUF_WR: cmd_target = (code[3:0] == `EP_CTRL_OUT) ?
                                udc_cmd_pkg::T_NONE : udc_cmd_pkg::T_BUF;
      `GRP_BUF_RD: cmd_target = (code[3:0] == `EP_CTRL_IN) ?
                                udc_cmd_pkg::T_NONE : udc_cmd_pkg::T_BUF;
      `GRP_CFG_WR, `GRP_CFG_RD: cmd_target = udc_cmd_pkg::T_CFG;
      `GRP_STATUS: cmd_target = udc_cmd_pkg::T_STAT;
      `GRP_STATUS_COPY: cmd_target = udc_cmd_pkg::T_COPY;
      default: begin
        case (code)
          `CMD_ERR_OUT, `CMD_ERR_IN: cmd_target = udc_cmd_pkg::T_ERR;
          `CMD_ADDR_WR, `CMD_ADDR_RD: cmd_target = udc_cmd_pkg::T_ADDR;
          `CMD_MODE_WR, `CMD_MODE_RD: cmd_target = udc_cmd_pkg::T_MODE;
          `CMD_HW_WR, `CMD_HW_RD: cmd_target = udc_cmd_pkg::T_HW;
          `CMD_IE_WR, `CMD_IE_RD: cmd_target = udc_cmd_pkg::T_IE;
          `CMD_DMACFG_WR, `CMD_DMACFG_RD: cmd_target = udc_cmd_pkg::T_DMACFG;
          `CMD_DMACNT_WR, `CMD_DMACNT_RD: cmd_target = udc_cmd_pkg::T_DMACNT;
          default: cmd_target = udc_cmd_pkg::T_NONE;
        endcase
      end
    endcase
  endfunction

  function automatic udc_cmd_pkg::ev_kind_t cmd_event(input logic [7:0] code);
    case (code[7:4])
      `GRP_STALL: cmd_event = udc_cmd_pkg::EV_STALL;
      `GRP_UNSTALL: cmd_event = udc_cmd_pkg::EV_UNSTALL;
      `GRP_VALIDATE: cmd_event = (code[3:0] == `EP_CTRL_OUT) ?
                                 udc_cmd_pkg::EV_NONE :
                                 udc_cmd_pkg::EV_VALIDATE;
      `GRP_CLEAR: cmd_event = (code[3:0] == `EP_CTRL_IN) ?
                              udc_cmd_pkg::EV_NONE : udc_cmd_pkg::EV_CLEAR;
      default: begin
        case (code)
          `CMD_SETUP_ACK: cmd_event = udc_cmd_pkg::EV_SETUP_ACK;
          `CMD_DEV_RESET: cmd_event = udc_cmd_pkg::EV_RESET;
          default: cmd_event = udc_cmd_pkg::EV_NONE;
        endcase
      end
    endcase
  endfunction

  function automatic logic cmd_reads(input logic [7:0] code);
    case (code[7:4])
      `GRP_BUF_WR, `GRP_CFG_WR: cmd_reads = 1'b0;
      `GRP_BUF_RD, `GRP_CFG_RD, `GRP_STATUS, `GRP_STATUS_COPY,
      `GRP_ERROR: cmd_reads = 1'b1;
      default: cmd_reads = code[`DIR_READ_BIT];
    endcase
  endfunction

  // Words after the length word, limited to the largest buffer
  function automatic logic [9:0] word_count(input logic [15:0] len);
    logic [15:0] clamped;
    clamped = (len > `BUF_MAX_LEN) ? `BUF_MAX_LEN : len;
    word_count = 10'((clamped + `LEN_ROUND) >> 1);
  endfunction

  // ==========================================================================
  // Access classification
  udc_cmd_pkg::target_t target_q, target_d;
  logic reads_q, len_pending_q, ie_hi_q;
  logic [3:0] ep_q;
  logic [9:0] words_left_q, words_left_d;
  logic [15:0] len_q;
  wire logic [7:0] code = bus_wdata[7:0];
  wire logic cmd_wr = bus_wr && cmd_data_select;
  wire logic active = (target_q != udc_cmd_pkg::T_NONE);
  wire logic data_wr = bus_wr && !cmd_data_select && active && !reads_q;
  wire logic data_rd = !bus_wr && bus_rd && !cmd_data_select && active &&
                       reads_q;
  wire logic data_any = data_wr || data_rd;
  wire logic soft_reset = cmd_wr && (code == `CMD_DEV_RESET);
  wire logic on_buf = (target_q == udc_cmd_pkg::T_BUF);
  wire logic [15:0] len_word = data_wr ? bus_wdata : buf_rd_data;
  wire logic last_word = !len_pending_q && (words_left_q == `WORDS_ONE);

  // Registers take one word, interrupt enable two, buffers length plus data
  wire udc_cmd_pkg::target_t cmd_tgt = cmd_target(code);
  wire logic [9:0] cmd_words = (cmd_tgt == udc_cmd_pkg::T_IE) ? `WORDS_IE :
                               `WORDS_ONE;

  assign words_left_d = (on_buf && len_pending_q) ? word_count(len_word) :
                        words_left_q - `WORDS_ONE;
  assign target_d = (words_left_d == `WORDS_NONE) ? udc_cmd_pkg::T_NONE :
                    target_q;

  // ==========================================================================
  // Phase tracking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= udc_cmd_pkg::T_NONE;
      reads_q <= 1'b0;
      ep_q <= `EP_CTRL_OUT;
      words_left_q <= `WORDS_NONE;
      len_pending_q <= 1'b0;
      ie_hi_q <= `IE_WORD_LOW;
      len_q <= `WORD_RESET;
    end else if (cmd_wr) begin
      target_q <= cmd_tgt;
      reads_q <= cmd_reads(code);
      ep_q <= code[3:0];
      words_left_q <= cmd_words;
      len_pending_q <= (cmd_tgt == udc_cmd_pkg::T_BUF);
      ie_hi_q <= `IE_WORD_LOW;
    end else if (data_any) begin
      target_q <= target_d;
      words_left_q <= words_left_d;
      len_pending_q <= 1'b0;
      ie_hi_q <= !ie_hi_q;
      if (on_buf && len_pending_q) begin
        len_q <= len_word;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  logic [15:0][7:0] cfg_q;
  udc_cmd_pkg::dev_cfg_t dev_q;
  wire logic [7:0] lo_byte = bus_wdata[7:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
      dev_q <= '0;
    end else if (soft_reset) begin
      cfg_q <= '0;
      dev_q <= '0;
    end else if (data_wr) begin
      case (target_q)
        udc_cmd_pkg::T_CFG: cfg_q[ep_q] <= lo_byte;
        udc_cmd_pkg::T_ADDR: dev_q.address <= lo_byte;
        udc_cmd_pkg::T_MODE: dev_q.mode <= lo_byte;
        udc_cmd_pkg::T_HW: dev_q.hw_config <= bus_wdata;
        udc_cmd_pkg::T_IE: begin
          if (ie_hi_q) begin
            dev_q.int_enable[31:16] <= bus_wdata;
          end else begin
            dev_q.int_enable[15:0] <= bus_wdata;
          end
        end
        udc_cmd_pkg::T_DMACFG: dev_q.dma_config <= bus_wdata;
        udc_cmd_pkg::T_DMACNT: dev_q.dma_count <= bus_wdata;
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  assign endpoint_config_reg = cfg_q;
  assign dev_cfg = dev_q;

  // ==========================================================================
  // Read data; byte-wide registers return a zero high byte
  logic [15:0] rdata_q;
  wire logic [15:0] ie_word = ie_hi_q ? dev_q.int_enable[31:16] :
                              dev_q.int_enable[15:0];
  wire logic [15:0] read_word =
    (target_q == udc_cmd_pkg::T_CFG) ? {`HI_BYTE_ZERO, cfg_q[ep_q]} :
    (target_q == udc_cmd_pkg::T_ADDR) ? {`HI_BYTE_ZERO, dev_q.address} :
    (target_q == udc_cmd_pkg::T_MODE) ? {`HI_BYTE_ZERO, dev_q.mode} :
    (target_q == udc_cmd_pkg::T_HW) ? dev_q.hw_config :
    (target_q == udc_cmd_pkg::T_IE) ? ie_word :
    (target_q == udc_cmd_pkg::T_DMACFG) ? dev_q.dma_config :
    (target_q == udc_cmd_pkg::T_DMACNT) ? dev_q.dma_count :
    (target_q == udc_cmd_pkg::T_STAT) ?
      {`HI_BYTE_ZERO, endpoint_status_reg[ep_q]} :
    (target_q == udc_cmd_pkg::T_COPY) ?
      {`HI_BYTE_ZERO, endpoint_status_reg[ep_q]} :
    (target_q == udc_cmd_pkg::T_ERR) ?
      {`HI_BYTE_ZERO, endpoint_error_reg[ep_q[0]]} :
    buf_rd_data;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `WORD_RESET;
    end else if (data_rd) begin
      rdata_q <= read_word;
    end
  end

  assign bus_rdata = rdata_q;
  assign buf_rd_req = data_rd && on_buf;

  // ==========================================================================
  // Buffer words and immediate actions towards the engine
  udc_cmd_pkg::buf_word_t buf_q, buf_d;
  udc_cmd_pkg::ep_cmd_t ev_q, ev_d;
  wire udc_cmd_pkg::ev_kind_t cmd_ev = cmd_event(code);
  wire logic status_clear = data_rd && (target_q == udc_cmd_pkg::T_STAT);

  assign buf_d.valid = data_wr && on_buf;
  assign buf_d.ep = ep_q;
  assign buf_d.data = bus_wdata;
  assign buf_d.is_len = len_pending_q;
  assign buf_d.last = last_word;
  assign buf_d.hi_valid = !(last_word && len_q[0]);

  // Copy reads are left out so no status bit moves
  assign ev_d.kind = cmd_wr ? cmd_ev :
                     status_clear ? udc_cmd_pkg::EV_STATUS_READ :
                     udc_cmd_pkg::EV_NONE;
  assign ev_d.ep = cmd_wr ? code[3:0] : ep_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= '0;
      ev_q <= '0;
    end else begin
      buf_q <= buf_d;
      ev_q <= ev_d;
    end
  end

  assign buf_wr = buf_q;
  assign ep_cmd = ev_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_len_word;
    data_wr && on_buf && len_pending_q;
  endsequence

  sequence s_odd_last;
    data_wr && on_buf && last_word && len_q[0];
  endsequence

  property p_reset_cmd;
    soft_reset |=> ep_cmd.kind == udc_cmd_pkg::EV_RESET &&
                   dev_cfg == '0 && endpoint_config_reg == '0;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset cmd failed");

  property p_stall;
    cmd_wr && code[7:4] == `GRP_STALL |=>
      ep_cmd.kind == udc_cmd_pkg::EV_STALL && ep_cmd.ep == $past(code[3:0]);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not issued");

  property p_cfg_write;
    data_wr && target_q == udc_cmd_pkg::T_CFG |=>
      endpoint_config_reg[$past(ep_q)] == $past(lo_byte) && !active;
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("cfg not stored");

  property p_ie_high;
    data_wr && target_q == udc_cmd_pkg::T_IE && ie_hi_q |=>
      dev_cfg.int_enable[31:16] == $past(bus_wdata) && !active;
  endproperty
  a_ie_high: assert property (p_ie_high)
    else $error("ie high word bad");

  property p_addr_read;
    data_rd && target_q == udc_cmd_pkg::T_ADDR |=>
      bus_rdata == {`HI_BYTE_ZERO, dev_cfg.address};
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("addr read bad");

  property p_copy_quiet;
    data_rd && target_q == udc_cmd_pkg::T_COPY |=>
      ep_cmd.kind == udc_cmd_pkg::EV_NONE;
  endproperty
  a_copy_quiet: assert property (p_copy_quiet)
    else $error("copy read acted");

  property p_status_read;
    status_clear |=> ep_cmd.kind == udc_cmd_pkg::EV_STATUS_READ &&
                     bus_rdata[7:0] == $past(endpoint_status_reg[ep_q]);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status bad");

  property p_word_count;
    s_len_word |=> words_left_q == word_count($past(bus_wdata)) &&
                   buf_wr.valid && buf_wr.is_len;
  endproperty
  a_word_count: assert property (p_word_count)
    else $error("count bad");

  property p_odd_tail;
    s_odd_last |=> buf_wr.valid && buf_wr.last && !buf_wr.hi_valid ##1
                   !buf_wr.valid;
  endproperty
  a_odd_tail: assert property (p_odd_tail)
    else $error("odd tail sent");

endmodule // usb_device_command_port
`default_nettype wire

/* rtl/udc_cmd_map.svh */
// Command codes, field positions, counts and reset values of the command port
`ifndef UDC_CMD_MAP_SVH
`define UDC_CMD_MAP_SVH
`define GRP_BUF_WR 4'h0
`define GRP_BUF_RD 4'h1
`define GRP_CFG_WR 4'h2
`define GRP_CFG_RD 4'h3
`define GRP_STALL 4'h4
`define GRP_STATUS 4'h5
`define GRP_VALIDATE 4'h6
`define GRP_CLEAR 4'h7
`define GRP_UNSTALL 4'h8
`define GRP_ERROR 4'hA
`define GRP_STATUS_COPY 4'hD
`define EP_CTRL_OUT 4'h0
`define EP_CTRL_IN 4'h1
`define CMD_ERR_OUT 8'hA0
`define CMD_ERR_IN 8'hA1
`define CMD_ADDR_WR 8'hB6
`define CMD_ADDR_RD 8'hB7
`define CMD_MODE_WR 8'hB8
`define CMD_MODE_RD 8'hB9
`define CMD_HW_WR 8'hBA
`define CMD_HW_RD 8'hBB
`define CMD_IE_WR 8'hC2
`define CMD_IE_RD 8'hC3
`define CMD_DMACFG_WR 8'hF0
`define CMD_DMACFG_RD 8'hF1
`define CMD_DMACNT_WR 8'hF2
`define CMD_DMACNT_RD 8'hF3
`define CMD_SETUP_ACK 8'hF4
`define CMD_DEV_RESET 8'hF6
`define DIR_READ_BIT 0
`define WORDS_ONE 10'h001
`define WORDS_IE 10'h002
`define WORDS_NONE 10'h000
`define IE_WORD_LOW 1'h0
`define BUF_MAX_LEN 16'h03FF
`define LEN_ROUND 16'h0001
`define BYTE_RESET 8'h00
`define WORD_RESET 16'h0000
`define IE_RESET 32'h0000_0000
`define HI_BYTE_ZERO 8'h00
`endif

/* rtl/udc_cmd_pkg.sv */
// Types shared by the command port and its surroundings
package udc_cmd_pkg;

  // Register or buffer chosen by the last command
  typedef enum logic [3:0] {
    T_NONE, T_CFG, T_ADDR, T_MODE, T_HW, T_IE, T_DMACFG, T_DMACNT,
    T_STAT, T_COPY, T_ERR, T_BUF
  } target_t;

  // Immediate actions handed to the USB engine
  typedef enum logic [2:0] {
    EV_NONE, EV_STALL, EV_UNSTALL, EV_VALIDATE, EV_CLEAR, EV_SETUP_ACK,
    EV_RESET, EV_STATUS_READ
  } ev_kind_t;

  typedef struct packed {
    ev_kind_t kind;
    logic [3:0] ep;
  } ep_cmd_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic [15:0] data;
    logic is_len;
    logic last;
    logic hi_valid;
  } buf_word_t;

  typedef struct packed {
    logic [7:0] address;
    logic [7:0] mode;
    logic [15:0] hw_config;
    logic [31:0] int_enable;
    logic [15:0] dma_config;
    logic [15:0] dma_count;
  } dev_cfg_t;

endpackage

/* verification/cpu_bus_model.sv */
// Processor bus master model for the command port
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input wire logic clock,
  // Processor bus
  output logic bus_wr,
  output logic bus_rd,
  output logic cmd_data_select,
  output logic [15:0] bus_wdata
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    cmd_data_select = 1'b0;
    bus_wdata = 16'h0000;
  end

  // ==========================================================
  // Accesses
  // One whole-word access, held through one rising edge
  task automatic go(input logic w, input logic s, input logic [15:0] d);
    bus_wr = w;
    bus_rd = !w;
    cmd_data_select = s;
    bus_wdata = d;
    @(posedge clock);
    #1;
  endtask

  // Command with a random high byte; codes 00, 11, 60 and 71 are never sent
  task automatic cmd(input logic [7:0] c);
    if (c != 8'h00 && c != 8'h11 && c != 8'h60 && c != 8'h71) begin
      go(1'b1, 1'b1, {8'($urandom), c});
    end
  endtask

  // Release the bus; data lines stop showing the last word
  task automatic idle();
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = ~bus_wdata;
    @(posedge clock);
    #1;
  endtask
endmodule // cpu_bus_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the command port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bus_wr, bus_rd, sel, buf_rd_req;
  logic [15:0] wdata, rdata, buf_rd_data, lastv;
  logic [15:0][7:0] st, cfg;
  logic [1:0][7:0] err;
  udc_cmd_pkg::buf_word_t buf_wr;
  udc_cmd_pkg::ep_cmd_t ep_cmd;
  udc_cmd_pkg::dev_cfg_t dev_cfg;
  logic [15:0] rd_mem [16];
  logic [3:0] rd_idx = 4'h0;
  logic [7:0] exp_cfg [16];
  logic [7:0] wc [5] = '{8'hB6, 8'hB8, 8'hBA, 8'hF0, 8'hF2};
  logic [15:0] wm [5] = '{16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  logic [24:0] notes [$];
  int failures = 0;
  int n_tests = 0;

  always #5 clock = ~clock;

  usb_device_command_port dut_u (.clock(clock), .rst_n(rst_n),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .cmd_data_select(sel),
    .bus_wdata(wdata), .bus_rdata(rdata), .endpoint_status_reg(st),
    .endpoint_error_reg(err), .buf_rd_data(buf_rd_data),
    .buf_rd_req(buf_rd_req), .buf_wr(buf_wr), .ep_cmd(ep_cmd),
    .endpoint_config_reg(cfg), .dev_cfg(dev_cfg));

  cpu_bus_model cpu_u (.clock(clock), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .cmd_data_select(sel), .bus_wdata(wdata));

  // ==========================================================
  // Engine side: buffer words handed out one per request
  assign buf_rd_data = rd_mem[rd_idx];
  always @(posedge clock) begin
    if (buf_rd_req === 1'b1) begin
      rd_idx <= rd_idx + 4'h1;
    end
  end

  // ==========================================================
  // Checking
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic take(input logic [24:0] seen);
    if (notes.size() == 0) begin
      check(seen, 25'h1FFFFFF);
    end else begin
      check(seen, notes.pop_front());
    end
  endtask

  function automatic logic [24:0] ev(input udc_cmd_pkg::ev_kind_t k,
                                     input logic [3:0] e);
    return {2'b10, 16'h0000, k, e};
  endfunction

  always @(posedge clock) begin : mon
    logic took;
    took = bus_rd && !bus_wr && !sel;
    #2;
    // Read data is loaded at the read edge and looked at just after it
    if (took) begin
      take(25'(rdata));
    end
    if (ep_cmd.kind !== udc_cmd_pkg::EV_NONE) begin
      take({2'b10, 16'h0000, ep_cmd});
    end
    if (buf_wr.valid !== 1'b0) begin
      take({2'b01, buf_wr.ep, buf_wr.is_len, buf_wr.last, buf_wr.hi_valid,
            buf_wr.data});
    end
  end

  // ==========================================================
  // Driving
  task automatic rd(input logic [15:0] e);
    notes.push_back(25'(e));
    lastv = e;
    cpu_u.go(1'b0, 1'b0, 16'($urandom));
  endtask

  task automatic wr(input logic [15:0] d);
    cpu_u.go(1'b1, 1'b0, d);
  endtask

  task automatic ev_op(input logic [7:0] c, input udc_cmd_pkg::ev_kind_t k);
    notes.push_back(ev(k, c[3:0]));
    cpu_u.cmd(c);
  endtask

  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin : main
    logic [15:0] v, w;
    logic [7:0] c;
    logic [3:0] p;
    int n;
    v = 16'($urandom(32'hDE06F8B5));
    for (int i = 0; i < 16; i++) begin
      st[i] = 8'($urandom);
      rd_mem[i] = 16'($urandom);
    end
    err = 16'($urandom);
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check(25'(dev_cfg !== '0), 25'h0);
    check(25'(cfg !== '0), 25'h0);
    // Endpoint configuration, high byte of every word random
    for (int i = 0; i < 16; i++) begin
      v = 16'($urandom);
      exp_cfg[i] = v[7:0];
      cpu_u.cmd(8'h20 + 8'(i));
      wr(v);
    end
    for (int i = 0; i < 16; i++) begin
      cpu_u.cmd(8'h30 + 8'(i));
      rd({8'h00, exp_cfg[i]});
    end
    // One-word registers; the surplus word and read are refused
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom);
      cpu_u.cmd(wc[i]);
      wr(v);
      wr(~v);
      cpu_u.cmd(wc[i] + 8'h01);
      rd(v & wm[i]);
      rd(v & wm[i]);
    end
    v = 16'($urandom);
    w = 16'($urandom);
    cpu_u.cmd(8'hC2);
    wr(v);
    wr(w);
    cpu_u.idle();
    check(25'(dev_cfg.int_enable), 25'({w[8:0], v}));
    check(25'(dev_cfg.int_enable[31:16]), 25'(w));
    cpu_u.cmd(8'hC3);
    rd(v);
    rd(w);
    cpu_u.cmd(8'hB6);
    rd(lastv);
    // Immediate actions, back to back
    for (int i = 0; i < 16; i++) begin
      c = 8'(i);
      ev_op(8'h40 | c, udc_cmd_pkg::EV_STALL);
      ev_op(8'h80 | c, udc_cmd_pkg::EV_UNSTALL);
      if (i != 0) ev_op(8'h60 | c, udc_cmd_pkg::EV_VALIDATE);
      if (i != 1) ev_op(8'h70 | c, udc_cmd_pkg::EV_CLEAR);
    end
    ev_op(8'hF4, udc_cmd_pkg::EV_SETUP_ACK);
    // Status, status copy and error reads
    for (int i = 0; i < 16; i++) begin
      c = 8'(i);
      cpu_u.cmd(8'h50 | c);
      rd({8'h00, st[i]});
      notes.push_back(ev(udc_cmd_pkg::EV_STATUS_READ, c[3:0]));
      cpu_u.cmd(8'hD0 | c);
      rd({8'h00, st[i]});
    end
    cpu_u.cmd(8'hA0);
    rd({8'h00, err[0]});
    cpu_u.cmd(8'hA1);
    rd({8'h00, err[1]});
    // Buffer loads, odd then even length, one surplus word
    for (int k = 0; k < 2; k++) begin
      n = 2 * int'($urandom % 4) + 1 + k;
      c = 8'h01 + 8'($urandom % 15);
      cpu_u.cmd(c);
      notes.push_back({2'b01, c[3:0], 3'b101, 16'(n)});
      wr(16'(n));
      for (int j = 0; j < (n + 1) / 2; j++) begin
        v = 16'($urandom);
        notes.push_back({2'b01, c[3:0], 1'b0, j == (n + 1) / 2 - 1,
          !(j == (n + 1) / 2 - 1 && n % 2 == 1), v});
        wr(v);
      end
      wr(16'($urandom));
    end
    // Buffer reads, length word first, one surplus read
    for (int k = 0; k < 2; k++) begin
      cpu_u.idle();
      c = k ? 8'h12 + 8'($urandom % 14) : 8'h10;
      n = int'($urandom % 6) + 1;
      p = rd_idx;
      rd_mem[p] = 16'(n);
      cpu_u.cmd(c);
      rd(16'(n));
      for (int j = 0; j < (n + 1) / 2; j++) begin
        rd(rd_mem[4'(p + 4'(j) + 4'h1)]);
      end
      rd(lastv);
    end
    cpu_u.idle();
    ev_op(8'hF6, udc_cmd_pkg::EV_RESET);
    cpu_u.idle();
    cpu_u.idle();
    check(25'(dev_cfg !== '0), 25'h0);
    check(25'(cfg !== '0), 25'h0);
    repeat (3) cpu_u.idle();
    check(25'(notes.size()), 25'h0);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
